// ==== logic/rfpu_top.sv ====
// rom fetch patch unit: register slave and fetch data substitution
//
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module rfpu_top (
  // clock and reset
  input  wire logic                                ref_clk,
  input  wire logic                                rst,
  // avalon-mm register slave
  input  wire logic [rfpu_pkg::BUS_AW-1:0]         avs_address,
  input  wire logic                                avs_read,
  input  wire logic                                avs_write,
  input  wire logic [rfpu_pkg::BUS_DW-1:0]         avs_writedata,
  input  wire logic [rfpu_pkg::BUS_BEW-1:0]        avs_byteenable,
  output logic      [rfpu_pkg::BUS_DW-1:0]         avs_readdata,
  output logic                                     avs_waitrequest,
  // rom fetch path from the cpu
  input  wire logic                                rom_rvalid,
  input  wire logic                                fetch_is_insn,
  input  wire logic                                fetch_in_rom,
  input  wire logic [rfpu_pkg::FETCH_AW-1:0]       fetch_addr,
  input  wire logic [rfpu_pkg::BYTE_W-1:0]         rom_rdata,
  // patched data back to the cpu
  output logic                                     fetch_rvalid,
  output logic      [rfpu_pkg::BYTE_W-1:0]         fetch_rdata,
  output logic      [rfpu_pkg::VEC_W-1:0]          patch_vector
);

  // ---------------- bus handshake ----------------
  logic                            wait_q;
  logic [rfpu_pkg::BUS_DW-1:0]     rdata_q;
  logic [rfpu_pkg::BUS_DW-1:0]     rdata_d;
  logic [rfpu_pkg::BYTE_W-1:0]     ctrl_q;
  logic [rfpu_pkg::BYTE_W-1:0]     ctrl_d;
  logic                            fvalid_q;
  logic [rfpu_pkg::BYTE_W-1:0]     fdata_q;
  logic [rfpu_pkg::BYTE_W-1:0]     fdata_d;
  logic [rfpu_pkg::VEC_W-1:0]      vec_q;

  wire bus_req  = avs_read || avs_write;
  // one wait state: the answer comes on the edge after the request appears
  wire bus_done = bus_req && !wait_q;
  wire wr_go    = avs_write && bus_done;

  wire hit_ctrl  = (avs_address == rfpu_pkg::OFS_CTRL);
  wire hit_low   = (avs_address == rfpu_pkg::OFS_ADDR_LOW);
  wire hit_high  = (avs_address == rfpu_pkg::OFS_ADDR_HIGH);
  wire hit_set   = (avs_address == rfpu_pkg::OFS_CTRL_SET);
  wire hit_clr   = (avs_address == rfpu_pkg::OFS_CTRL_CLR);

  wire [rfpu_pkg::BYTE_W-1:0] wr_byte = avs_writedata[rfpu_pkg::BYTE_W-1:0];
  wire                        be0     = avs_byteenable[0];

  // ---------------- control register ----------------
  wire [rfpu_pkg::SEL_W-1:0] ch_sel =
    ctrl_q[rfpu_pkg::CTRL_SEL_LSB +: rfpu_pkg::SEL_W];
  wire [rfpu_pkg::NUM_CH-1:0] ch_en =
    ctrl_q[rfpu_pkg::CTRL_EN_LSB +: rfpu_pkg::NUM_CH];

  // whole-byte store, or set/clear of single bits without read-modify-write
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_go && be0 && hit_ctrl) begin
      ctrl_d = wr_byte & rfpu_pkg::CTRL_WR_MASK;
    end else if (wr_go && be0 && hit_set) begin
      ctrl_d = ctrl_q | (wr_byte & rfpu_pkg::CTRL_WR_MASK);
    end else if (wr_go && be0 && hit_clr) begin
      ctrl_d = ctrl_q & ~(wr_byte & rfpu_pkg::CTRL_WR_MASK);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= rfpu_pkg::CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ---------------- pointer channels ----------------
  // rom_rvalid covers every rom read; only instruction fetches may match
  wire fetch_ok = rom_rvalid && fetch_is_insn && fetch_in_rom;

  logic [rfpu_pkg::FETCH_AW-1:0] ptr [rfpu_pkg::NUM_CH];
  logic [rfpu_pkg::NUM_CH-1:0]   hits;
  logic [rfpu_pkg::NUM_CH-1:0]   ch_dec;

  genvar g;
  generate
    for (g = 0; g < rfpu_pkg::NUM_CH; g++) begin : g_ch
      assign ch_dec[g] = (ch_sel == rfpu_pkg::SEL_W'(g));
      rfpu_channel u_ch (
        .clk        (ref_clk),
        .rst        (rst),
        .load_low   (wr_go && hit_low && ch_dec[g]),
        .load_high  (wr_go && hit_high && be0 && ch_dec[g]),
        .low_be     (avs_byteenable[1:0]),
        .wdata_low  (avs_writedata[rfpu_pkg::LOW_W-1:0]),
        .wdata_high (avs_writedata[rfpu_pkg::HIGH_W-1:0]),
        .enable     (ch_en[g]),
        .fetch_ok   (fetch_ok),
        .fetch_addr (fetch_addr),
        .pointer    (ptr[g]),
        .hit        (hits[g])
      );
    end
  endgenerate

  // ---------------- substitution ----------------
  logic                          any_hit;
  logic [rfpu_pkg::BYTE_W-1:0]   sub_opcode;
  logic [rfpu_pkg::VEC_W-1:0]    sub_vector;

  rfpu_select u_sel (
    .hits    (hits),
    .any_hit (any_hit),
    .opcode  (sub_opcode),
    .vector  (sub_vector)
  );

  // a single byte replaces the rom byte; following bytes pass untouched
  // there is deliberately no sticky hit flag: a match on a prefetch that
  // the cpu later discards would leave it falsely set
  assign fdata_d = any_hit ? sub_opcode : rom_rdata;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fvalid_q <= 1'b0;
      fdata_q  <= '0;
      vec_q    <= '0;
    end else begin
      fvalid_q <= rom_rvalid;
      fdata_q  <= fdata_d;
      vec_q    <= any_hit ? sub_vector : '0;
    end
  end

  // ---------------- read data ----------------
  wire [rfpu_pkg::FETCH_AW-1:0] sel_ptr = ptr[ch_sel];

  always_comb begin
    rdata_d = '0;
    if (hit_ctrl) begin
      rdata_d[rfpu_pkg::BYTE_W-1:0] = ctrl_q;
    end else if (hit_low) begin
      rdata_d[rfpu_pkg::LOW_W-1:0] = sel_ptr[rfpu_pkg::LOW_W-1:0];
    end else if (hit_high) begin
      rdata_d[rfpu_pkg::HIGH_W-1:0] =
        sel_ptr[rfpu_pkg::FETCH_AW-1:rfpu_pkg::LOW_W];
    end
  end

  // waitrequest rests high; it drops for one cycle to close each request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
    end else begin
      wait_q <= !(bus_req && wait_q);
      if (avs_read && wait_q) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;
  assign fetch_rvalid    = fvalid_q;
  assign fetch_rdata     = fdata_q;
  assign patch_vector    = vec_q;

endmodule

// ==== logic/rfpu_pkg.sv ====
// constants shared by the rom fetch patch unit
package rfpu_pkg;

  localparam int FETCH_AW = 20;
  localparam int LOW_W    = 16;
  localparam int HIGH_W   = FETCH_AW - LOW_W;
  localparam int BYTE_W   = 8;
  localparam int NUM_CH   = 4;
  localparam int SEL_W    = 2;
  localparam int VEC_W    = 16;
  localparam int BUS_AW   = 5;
  localparam int BUS_DW   = 32;
  localparam int BUS_BEW  = BUS_DW / BYTE_W;

  // control register layout
  localparam logic [BYTE_W-1:0] CTRL_RESET   = 8'h00;
  localparam logic [BYTE_W-1:0] CTRL_WR_MASK = 8'hF3;
  localparam int                CTRL_SEL_LSB = 0;
  localparam int                CTRL_EN_LSB  = 4;

  // byte offsets on the register bus
  localparam logic [BUS_AW-1:0] OFS_CTRL      = 5'h00;
  localparam logic [BUS_AW-1:0] OFS_ADDR_LOW  = 5'h04;
  localparam logic [BUS_AW-1:0] OFS_ADDR_HIGH = 5'h08;
  localparam logic [BUS_AW-1:0] OFS_CTRL_SET  = 5'h0C;
  localparam logic [BUS_AW-1:0] OFS_CTRL_CLR  = 5'h10;

  localparam logic [FETCH_AW-1:0] PTR_RESET = 20'h00000;

  // one-byte table-call opcodes and their table entries, per channel
  localparam logic [BYTE_W-1:0] PATCH_OPCODE [NUM_CH] =
    '{8'hFC, 8'hFD, 8'hFE, 8'hFF};
  localparam logic [VEC_W-1:0]  PATCH_VECTOR [NUM_CH] =
    '{16'h0078, 16'h007A, 16'h007C, 16'h007E};

endpackage

// ==== logic/rfpu_channel.sv ====
// one address pointer channel with its comparator
`timescale 1ns/1ps
module rfpu_channel (
  // clock and reset
  input  wire logic                               clk,
  input  wire logic                               rst,
  // pointer load
  input  wire logic                               load_low,
  input  wire logic                               load_high,
  input  wire logic [1:0]                         low_be,
  input  wire logic [rfpu_pkg::LOW_W-1:0]         wdata_low,
  input  wire logic [rfpu_pkg::HIGH_W-1:0]        wdata_high,
  // compare
  input  wire logic                               enable,
  input  wire logic                               fetch_ok,
  input  wire logic [rfpu_pkg::FETCH_AW-1:0]      fetch_addr,
  output logic      [rfpu_pkg::FETCH_AW-1:0]      pointer,
  output logic                                    hit
);

  logic [rfpu_pkg::FETCH_AW-1:0] ptr_q;
  logic [rfpu_pkg::FETCH_AW-1:0] ptr_d;

  // per-byte loads keep a half-written pointer consistent
  always_comb begin
    ptr_d = ptr_q;
    if (load_low && low_be[0]) begin
      ptr_d[rfpu_pkg::BYTE_W-1:0] = wdata_low[rfpu_pkg::BYTE_W-1:0];
    end
    if (load_low && low_be[1]) begin
      ptr_d[rfpu_pkg::LOW_W-1:rfpu_pkg::BYTE_W] =
        wdata_low[rfpu_pkg::LOW_W-1:rfpu_pkg::BYTE_W];
    end
    if (load_high) begin
      ptr_d[rfpu_pkg::FETCH_AW-1:rfpu_pkg::LOW_W] = wdata_high;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_q <= rfpu_pkg::PTR_RESET;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  assign pointer = ptr_q;
  assign hit     = enable && fetch_ok && (ptr_q == fetch_addr);

endmodule

// ==== logic/rfpu_select.sv ====
// priority pick of the matching channel and its substitute opcode
`timescale 1ns/1ps
module rfpu_select (
  // match vector
  input  wire logic [rfpu_pkg::NUM_CH-1:0]  hits,
  // result
  output logic                              any_hit,
  output logic      [rfpu_pkg::BYTE_W-1:0]  opcode,
  output logic      [rfpu_pkg::VEC_W-1:0]   vector
);

  // scan downward so the lowest matching channel is written last
  always_comb begin
    opcode = rfpu_pkg::PATCH_OPCODE[0];
    vector = rfpu_pkg::PATCH_VECTOR[0];
    for (int i = rfpu_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (hits[i]) begin
        opcode = rfpu_pkg::PATCH_OPCODE[i];
        vector = rfpu_pkg::PATCH_VECTOR[i];
      end
    end
  end

  assign any_hit = |hits;

endmodule

// ==== sim/rfpu_monitor.sv ====
// port assertions and covers for the rom fetch patch unit
`timescale 1ns/1ps
module rfpu_monitor (
  // clock and reset
  input wire logic                        ref_clk,
  input wire logic                        rst,
  // register bus
  input wire logic [rfpu_pkg::BUS_AW-1:0] avs_address,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic [rfpu_pkg::BUS_DW-1:0] avs_readdata,
  input wire logic                        avs_waitrequest,
  // fetch path
  input wire logic                        rom_rvalid,
  input wire logic                        fetch_is_insn,
  input wire logic                        fetch_in_rom,
  input wire logic [rfpu_pkg::BYTE_W-1:0] rom_rdata,
  input wire logic                        fetch_rvalid,
  input wire logic [rfpu_pkg::BYTE_W-1:0] fetch_rdata,
  input wire logic [rfpu_pkg::VEC_W-1:0]  patch_vector
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus request not answered after one wait state");
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse)
    else $error("waitrequest low for more than one cycle");
  property p_valid_lat;
    1'b1 |=> fetch_rvalid == $past(rom_rvalid);
  endproperty
  a_valid_lat: assert property (p_valid_lat)
    else $error("fetch valid not one cycle after rom valid");
  property p_data_pass;
    rom_rvalid && !(fetch_is_insn && fetch_in_rom) |=>
      fetch_rdata == $past(rom_rdata) && patch_vector == 16'h0000;
  endproperty
  a_data_pass: assert property (p_data_pass)
    else $error("non instruction or non rom access was patched");
  property p_op_vec;
    patch_vector != 16'h0000 |-> fetch_rvalid && fetch_rdata[7:2] == 6'h3F
      && patch_vector == {9'h000, 4'hF, fetch_rdata[1:0], 1'b0};
  endproperty
  a_op_vec: assert property (p_op_vec)
    else $error("opcode and table entry disagree");
  property p_reset_clear;
    $fell(rst) |-> avs_waitrequest && !fetch_rvalid
      && patch_vector == 16'h0000;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("outputs not idle after reset");
  property p_ctrl_rsv;
    !avs_waitrequest && avs_read && avs_address == rfpu_pkg::OFS_CTRL |->
      avs_readdata[31:8] == 24'h000000 && avs_readdata[3:2] == 2'b00;
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv)
    else $error("control read shows reserved bits");
  property p_unmapped;
    !avs_waitrequest && avs_read && avs_address > 5'h10 |->
      avs_readdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  c_patch3: cover property (patch_vector == 16'h007E);
  c_b2b: cover property (!avs_waitrequest ##1 avs_read);
  c_pass: cover property (fetch_rvalid && patch_vector == 16'h0000);
endmodule
bind rfpu_top rfpu_monitor u_mon (.*);

// ==== sim/rfpu_rom_model.sv ====
// behavioural mask rom feeding the fetch path
`timescale 1ns/1ps
module rfpu_rom_model (
  // fetch address in, stored byte out
  input wire logic [rfpu_pkg::FETCH_AW-1:0] fetch_addr,
  output logic     [rfpu_pkg::BYTE_W-1:0]   rom_rdata
);
  // every address bit shows in the byte so a wrong pass-through is visible
  assign rom_rdata = fetch_addr[7:0] ^ fetch_addr[15:8]
                     ^ {4'h3, fetch_addr[19:16]};
endmodule

// ==== sim/tb_rfpu_top.sv ====
// self-checking bench for the rom fetch patch unit
`timescale 1ns/1ps
module tb_rfpu_top;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, seed = 32'h7E4652A2;
  logic [3:0]  avs_byteenable, be;
  logic [19:0] fetch_addr, a20;
  logic [7:0]  rom_rdata, fetch_rdata;
  logic [15:0] patch_vector;
  logic        ref_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic        rom_rvalid, fetch_is_insn, fetch_in_rom, fetch_rvalid;
  int          miscompares, n_compared, ctrl, i, k;
  int          ptr [4];
  rfpu_top u_dut (.*);
  rfpu_rom_model u_rom (.*);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(logic wr, logic [4:0] a, logic [31:0] d);
    int n;
    @(posedge ref_clk);
    {avs_read, avs_write} <= {!wr, wr};
    {avs_address, avs_writedata, avs_byteenable} <= {a, d, be};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    {avs_read, avs_write} <= 2'b00;
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      end_sim();
    end
  endtask
  task automatic rdchk(logic [4:0] a, int e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic set_ptr(int ch, logic [19:0] a);
    ctrl = (ctrl & 'hF0) | ch;
    bus(1'b1, 5'h00, ctrl);
    bus(1'b1, 5'h04, {16'h0000, a[15:0]});
    bus(1'b1, 5'h08, {28'h0, a[19:16]});
    ptr[ch] = a;
  endtask
  // one byte launched; lowest enabled matching channel wins in the model
  task automatic fetch(logic [19:0] a, logic insn, logic inrom);
    logic [7:0]  eo;
    logic [15:0] ev;
    @(posedge ref_clk);
    {rom_rvalid, fetch_addr} <= {1'b1, a};
    {fetch_is_insn, fetch_in_rom} <= {insn, inrom};
    @(posedge ref_clk);
    rom_rvalid <= 1'b0;
    eo = rom_rdata;
    ev = 16'h0000;
    for (int ch = 3; ch >= 0; ch--)
      if (insn && inrom && ctrl[4+ch] && ptr[ch] == int'(a)) begin
        eo = 8'(8'hFC + ch);
        ev = 16'(16'h0078 + 2 * ch);
      end
    #1;
    chk(fetch_rvalid, 1);
    chk(fetch_rdata, eo);
    chk(patch_vector, ev);
  endtask
  initial begin
    {rst, avs_read, avs_write} = 3'b100;
    {rom_rvalid, fetch_is_insn, fetch_in_rom} = 3'b000;
    be = 4'hF;
    {avs_address, avs_writedata, avs_byteenable, fetch_addr} = '0;
    {miscompares, n_compared, ctrl} = '0;
    ptr = '{0, 0, 0, 0};
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rdchk(5'h00, 0);
    for (i = 3; i >= 0; i--) begin
      // bit 8 set keeps every pointer clear of the call-table entries
      a20 = 20'(rnd()) | 20'h00100;
      set_ptr(i, a20);
    end
    for (i = 0; i < 4; i++) begin
      ctrl = i;
      bus(1'b1, 5'h00, ctrl);
      rdchk(5'h04, ptr[i] & 'hFFFF);
      rdchk(5'h08, ptr[i] >> 16);
    end
    bus(1'b1, 5'h0C, 32'h000000F0);
    ctrl = ctrl | 'hF0;
    rdchk(5'h00, ctrl);
    for (i = 0; i < 4; i++) begin
      fetch(20'(ptr[i]), 1'b1, 1'b1);
      fetch(20'(ptr[i] + 1), 1'b1, 1'b1);
      fetch(20'(ptr[i]), 1'b0, 1'b1);
      fetch(20'(ptr[i]), 1'b1, 1'b0);
    end
    set_ptr(1, 20'(ptr[0]));
    fetch(20'(ptr[0]), 1'b1, 1'b1);
    bus(1'b1, 5'h10, 32'h00000010);
    ctrl = ctrl & 'hE1;
    fetch(20'(ptr[0]), 1'b1, 1'b1);
    bus(1'b1, 5'h14, 32'hFFFFFFFF);
    rdchk(5'h14, 0);
    // upper low-register byte only, into the selected channel 1
    be = 4'h2;
    bus(1'b1, 5'h04, 32'h0000A5A5);
    ptr[1] = (ptr[1] & 'hF00FF) | 'hA500;
    // control ignores a write without byte lane 0
    be = 4'h0;
    bus(1'b1, 5'h00, 32'h00000000);
    be = 4'hF;
    rdchk(5'h04, ptr[1] & 'hFFFF);
    rdchk(5'h00, ctrl);
    for (i = 0; i < 40; i++) begin
      k = rnd();
      a20 = k[2] ? 20'(ptr[k & 3]) : 20'(rnd());
      fetch(a20, k[8], k[9]);
    end
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    ctrl = 0;
    ptr = '{0, 0, 0, 0};
    rdchk(5'h00, 0);
    rdchk(5'h04, 0);
    rdchk(5'h08, 0);
    fetch(20'h00000, 1'b1, 1'b1);
    end_sim();
  end
endmodule
